// [tba_defs.svh]
// Constants for the 16-bit timer byte-access block: byte addresses, reference values, reset values.
// Assumes inclusion by the package, the design module, the core model and the bench.
`ifndef TBA_DEFS_SVH
`define TBA_DEFS_SVH

`define TBA_ADDR_W          3
`define TBA_ADDR_COUNT_LO   3'h0
`define TBA_ADDR_COUNT_HI   3'h1
`define TBA_ADDR_CMPA_LO    3'h2
`define TBA_ADDR_CMPA_HI    3'h3
`define TBA_ADDR_CMPB_LO    3'h4
`define TBA_ADDR_CMPB_HI    3'h5
`define TBA_ADDR_CAP_LO     3'h6
`define TBA_ADDR_CAP_HI     3'h7

`define TBA_FLOOR_VALUE     16'h0000
`define TBA_MAX_VALUE       16'hffff
`define TBA_TOP_8BIT        16'h00ff
`define TBA_TOP_9BIT        16'h01ff
`define TBA_TOP_10BIT       16'h03ff

`define TBA_LATCH_RESET     8'h00
`define TBA_REG_RESET       16'h0000
`define TBA_RDATA_RESET     8'h00

`endif

// [tba_pkg.sv]
// Types for the 16-bit timer byte-access block.
// Assumes tba_defs.svh is on the include path.
`include "tba_defs.svh"

package tba_pkg;

  typedef enum logic [3:0] {
    TBA_WM_NORMAL     = 4'h0,
    TBA_WM_PC8        = 4'h1,
    TBA_WM_PC9        = 4'h2,
    TBA_WM_PC10       = 4'h3,
    TBA_WM_CTC_A      = 4'h4,
    TBA_WM_FAST8      = 4'h5,
    TBA_WM_FAST9      = 4'h6,
    TBA_WM_FAST10     = 4'h7,
    TBA_WM_PFC_CAP    = 4'h8,
    TBA_WM_PFC_A      = 4'h9,
    TBA_WM_PC_CAP     = 4'ha,
    TBA_WM_PC_A       = 4'hb,
    TBA_WM_CTC_CAP    = 4'hc,
    TBA_WM_RESERVED   = 4'hd,
    TBA_WM_FAST_CAP   = 4'he,
    TBA_WM_FAST_A     = 4'hf
  } tba_wave_mode_t;

endpackage : tba_pkg

// [tba_timer16_byte_access.sv]
// Byte-wide access to the 16-bit count, compare and capture registers of one timer.
// Assumes a core on the same clock issuing one-cycle read or write strobes on an 8-bit bus,
// and counting and capture logic on the same clock driving the step, clear and capture inputs.
//
// Overview of operation
// - Flag floor point when count equals zero.
// - Flag absolute maximum when count is all ones.
// - Pick upper limit from mode: fixed, A, capture.
// - Sixteen-bit registers reached by two byte accesses.
// - One shared high-byte latch for all registers.
// - Low byte address does the real transfer.
// - Low write loads latch plus bus byte.
// - Low read copies upper byte into latch.
// - Compare reads bypass the latch entirely.
// - Latch kept after low write for reuse.
// - Core count write beats clear and step.
// - Capture writable only when it sets limit.
`timescale 1ns/1ps
`include "tba_defs.svh"

module tba_timer16_byte_access
  import tba_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    clkEn,
  input  wire logic [`TBA_ADDR_W-1:0]  busAddr,
  input  wire logic                    busWrite,
  input  wire logic                    busRead,
  input  wire logic [7:0]              busWdata,
  output logic      [7:0]              busRdata,
  input  wire logic [3:0]              waveformModeSelect,
  input  wire logic                    countStep,
  input  wire logic                    countDown,
  input  wire logic                    countClear,
  input  wire logic                    captureStrobe,
  output logic      [15:0]             timerCountValue,
  output logic      [15:0]             compareValueA,
  output logic      [15:0]             compareValueB,
  output logic      [15:0]             captureValue,
  output logic      [15:0]             topValue,
  output logic                         countFloorPoint,
  output logic                         countMaxPoint,
  output logic                         countTopPoint
);

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decoding.

  function automatic logic captureIsTop(input logic [3:0] mode);
    case (tba_wave_mode_t'(mode))
      TBA_WM_PFC_CAP, TBA_WM_PC_CAP, TBA_WM_CTC_CAP, TBA_WM_FAST_CAP: captureIsTop = 1'b1;
      default: captureIsTop = 1'b0;
    endcase
  endfunction : captureIsTop

  function automatic logic [15:0] topFor(input logic [3:0] mode, input logic [15:0] cmpA,
                                         input logic [15:0] cap);
    case (tba_wave_mode_t'(mode))
      TBA_WM_PC8, TBA_WM_FAST8:                                     topFor = `TBA_TOP_8BIT;
      TBA_WM_PC9, TBA_WM_FAST9:                                     topFor = `TBA_TOP_9BIT;
      TBA_WM_PC10, TBA_WM_FAST10:                                   topFor = `TBA_TOP_10BIT;
      TBA_WM_CTC_A, TBA_WM_PFC_A, TBA_WM_PC_A, TBA_WM_FAST_A:       topFor = cmpA;
      TBA_WM_PFC_CAP, TBA_WM_PC_CAP, TBA_WM_CTC_CAP, TBA_WM_FAST_CAP: topFor = cap;
      default:                                                      topFor = `TBA_MAX_VALUE;
    endcase
  endfunction : topFor

  ////////////////////////////////////////////////////////////////////////////////
  // Access decoding.

  logic [7:0] hiLatch;
  logic       wrCountLo;
  logic       wrCmpALo;
  logic       wrCmpBLo;
  logic       wrCapLo;
  logic       wrAnyHi;

  assign wrCountLo = clkEn && busWrite && (busAddr == `TBA_ADDR_COUNT_LO);
  assign wrCmpALo  = clkEn && busWrite && (busAddr == `TBA_ADDR_CMPA_LO);
  assign wrCmpBLo  = clkEn && busWrite && (busAddr == `TBA_ADDR_CMPB_LO);
  assign wrCapLo   = clkEn && busWrite && (busAddr == `TBA_ADDR_CAP_LO)
                     && captureIsTop(waveformModeSelect);
  assign wrAnyHi   = clkEn && busWrite && busAddr[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Shared high-byte latch.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hiLatch <= `TBA_LATCH_RESET;
    end else if (wrAnyHi) begin
      hiLatch <= busWdata;
    end else if (clkEn && busRead && !busWrite) begin
      case (busAddr)
        `TBA_ADDR_COUNT_LO: hiLatch <= timerCountValue[15:8];
        `TBA_ADDR_CAP_LO:   hiLatch <= captureValue[15:8];
        default:            hiLatch <= hiLatch;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busRdata <= `TBA_RDATA_RESET;
    end else if (clkEn && busRead) begin
      case (busAddr)
        `TBA_ADDR_COUNT_LO: busRdata <= timerCountValue[7:0];
        `TBA_ADDR_CMPA_LO:  busRdata <= compareValueA[7:0];
        `TBA_ADDR_CMPA_HI:  busRdata <= compareValueA[15:8];
        `TBA_ADDR_CMPB_LO:  busRdata <= compareValueB[7:0];
        `TBA_ADDR_CMPB_HI:  busRdata <= compareValueB[15:8];
        `TBA_ADDR_CAP_LO:   busRdata <= captureValue[7:0];
        default:            busRdata <= hiLatch;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Count register.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timerCountValue <= `TBA_REG_RESET;
    end else if (wrCountLo) begin
      timerCountValue <= {hiLatch, busWdata};
    end else if (clkEn && countClear) begin
      timerCountValue <= `TBA_FLOOR_VALUE;
    end else if (clkEn && countStep) begin
      timerCountValue <= countDown ? timerCountValue - 16'h0001 : timerCountValue + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and capture registers.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      compareValueA <= `TBA_REG_RESET;
      compareValueB <= `TBA_REG_RESET;
    end else begin
      if (wrCmpALo) begin
        compareValueA <= {hiLatch, busWdata};
      end
      if (wrCmpBLo) begin
        compareValueB <= {hiLatch, busWdata};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      captureValue <= `TBA_REG_RESET;
    end else if (wrCapLo) begin
      captureValue <= {hiLatch, busWdata};
    end else if (clkEn && captureStrobe) begin
      captureValue <= timerCountValue;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference points, registered one cycle after the values they describe.

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      topValue        <= `TBA_MAX_VALUE;
      countFloorPoint <= 1'b0;
      countMaxPoint   <= 1'b0;
      countTopPoint   <= 1'b0;
    end else if (clkEn) begin
      topValue        <= topFor(waveformModeSelect, compareValueA, captureValue);
      countFloorPoint <= (timerCountValue == `TBA_FLOOR_VALUE);
      countMaxPoint   <= (timerCountValue == `TBA_MAX_VALUE);
      countTopPoint   <= (timerCountValue == topFor(waveformModeSelect, compareValueA, captureValue));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_low_write_load: assert property (
    wrCountLo |=> timerCountValue == {$past(hiLatch), $past(busWdata)})
    else $error("Count low write did not load latch and bus byte.");

  a_write_beats_count: assert property (
    wrCountLo && (countClear || countStep) |=> timerCountValue[7:0] == $past(busWdata))
    else $error("Count operation overrode a core write.");

  a_high_write_latch: assert property (
    wrAnyHi |=> hiLatch == $past(busWdata) && ($stable(timerCountValue) || $past(countStep || countClear)))
    else $error("High byte write did more than load the latch.");

  a_latch_kept: assert property (
    clkEn && busWrite && !busAddr[0] |=> $stable(hiLatch))
    else $error("Latch changed on a low byte write.");

  a_low_read_copy: assert property (
    clkEn && busRead && !busWrite && busAddr == `TBA_ADDR_COUNT_LO
    ##1 clkEn && !busRead && !busWrite
    ##1 clkEn && busRead && !busWrite && busAddr == `TBA_ADDR_COUNT_HI
    |=> busRdata == $past(timerCountValue[15:8], 3))
    else $error("High byte read did not match earlier low byte read.");

  a_compare_direct: assert property (
    clkEn && busRead && !busWrite && busAddr == `TBA_ADDR_CMPB_HI
    |=> busRdata == $past(compareValueB[15:8]) && $stable(hiLatch))
    else $error("Compare read went through the latch.");

  a_floor_flag: assert property (
    clkEn |=> countFloorPoint == ($past(timerCountValue) == `TBA_FLOOR_VALUE))
    else $error("Floor flag wrong.");

  a_max_flag: assert property (
    clkEn |=> countMaxPoint == ($past(timerCountValue) == `TBA_MAX_VALUE))
    else $error("Maximum flag wrong.");

  a_top_select: assert property (
    clkEn |=> topValue == topFor($past(waveformModeSelect), $past(compareValueA), $past(captureValue)))
    else $error("Upper limit selection wrong.");

  a_capture_guard: assert property (
    clkEn && busWrite && busAddr == `TBA_ADDR_CAP_LO && !captureIsTop(waveformModeSelect) && !captureStrobe
    |=> $stable(captureValue))
    else $error("Capture register written in a mode that forbids it.");

  c_count_write: cover property (wrAnyHi ##2 wrCountLo);
  c_count_read: cover property (clkEn && busRead && busAddr == `TBA_ADDR_COUNT_LO
                                ##2 clkEn && busRead && busAddr == `TBA_ADDR_COUNT_HI);
  c_shared_high: cover property (wrAnyHi ##2 wrCmpALo ##2 wrCmpBLo);
  c_capture_top: cover property (wrCapLo);

endmodule : tba_timer16_byte_access

// [tba_core_model.sv]
// Model of the processor core on the 8-bit bus of the timer byte-access block.
// Assumes the same clock as the block; the bench calls its tasks hierarchically.
`timescale 1ns/1ps
`include "tba_defs.svh"

module tba_core_model (
  input  wire logic                   clk,
  input  wire logic [7:0]             busRdata,
  output logic      [`TBA_ADDR_W-1:0] busAddr,
  output logic                        busWrite,
  output logic                        busRead,
  output logic      [7:0]             busWdata
);

  initial begin
    busAddr = '0;
    busWrite = 1'b0;
    busRead = 1'b0;
    busWdata = 8'h00;
  end

  ////////////////////////////////////////////////////////////////
  // One byte cycle, held across the taking edge, then released.
  task automatic byte_op(input logic wr, input logic [2:0] addr, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk);
    #1;
    busWrite = wr;
    busRead = !wr;
    busAddr = addr;
    busWdata = wd;
    @(posedge clk);
    #1;
    rd = busRdata;
    busWrite = 1'b0;
    busRead = 1'b0;
    busAddr = ~addr;
    busWdata = ~wd;
  endtask : byte_op

  // Whole 16-bit accesses, never split by other traffic.
  task automatic write16(input logic [2:0] lo, input logic [15:0] val);
    logic [7:0] junk;
    byte_op(1'b1, lo + 3'h1, val[15:8], junk);
    byte_op(1'b1, lo, val[7:0], junk);
  endtask : write16

  task automatic read16(input logic [2:0] lo, output logic [15:0] val);
    byte_op(1'b0, lo, 8'h00, val[7:0]);
    byte_op(1'b0, lo + 3'h1, 8'h00, val[15:8]);
  endtask : read16

endmodule : tba_core_model

// [tba_timer16_byte_access_bench.sv]
// Self-checking bench for the timer byte-access block.
// Assumes the core model drives the byte bus; counter inputs are driven here.
`timescale 1ns/1ps
`include "tba_defs.svh"

module tba_timer16_byte_access_bench;
  import tba_pkg::*;

  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic                   clkEn = 1'b1;
  logic [`TBA_ADDR_W-1:0] busAddr;
  logic                   busWrite, busRead;
  logic [7:0]             busWdata, busRdata, junk;
  logic [3:0]             waveformModeSelect = 4'h0;
  logic                   countStep = 1'b0, countDown = 1'b0, countClear = 1'b0, captureStrobe = 1'b0;
  logic [15:0]            timerCountValue, compareValueA, compareValueB, captureValue, topValue, v;
  logic                   countFloorPoint, countMaxPoint, countTopPoint;
  int                     badCount = 0, nCompared = 0;

  always #10 clk = ~clk;

  tba_core_model u_core (.clk(clk), .busRdata(busRdata), .busAddr(busAddr), .busWrite(busWrite),
    .busRead(busRead), .busWdata(busWdata));

  tba_timer16_byte_access u_dut (.clk(clk), .rst(rst), .clkEn(clkEn), .busAddr(busAddr), .busWrite(busWrite),
    .busRead(busRead), .busWdata(busWdata), .busRdata(busRdata), .waveformModeSelect(waveformModeSelect),
    .countStep(countStep), .countDown(countDown), .countClear(countClear), .captureStrobe(captureStrobe),
    .timerCountValue(timerCountValue), .compareValueA(compareValueA), .compareValueB(compareValueB),
    .captureValue(captureValue), .topValue(topValue), .countFloorPoint(countFloorPoint),
    .countMaxPoint(countMaxPoint), .countTopPoint(countTopPoint));

  ////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_core.byte_op(1'b1, a, d, junk);
  endtask : wr

  function automatic logic [15:0] top_for(input logic [3:0] m);
    case (m)
      4'h1, 4'h5: top_for = `TBA_TOP_8BIT;
      4'h2, 4'h6: top_for = `TBA_TOP_9BIT;
      4'h3, 4'h7: top_for = `TBA_TOP_10BIT;
      4'h4, 4'h9, 4'hb, 4'hf: top_for = 16'ha55a;
      4'h8, 4'ha, 4'hc, 4'he: top_for = 16'h0333;
      default: top_for = `TBA_MAX_VALUE;
    endcase
  endfunction : top_for

  ////////////////////////////////////////////////////////////////
  task automatic t_reset_latch;
    tick(1);
    check("floor", {15'h0, countFloorPoint}, 16'h0001);
    wr(`TBA_ADDR_COUNT_LO, 8'h34);
    check("count", timerCountValue, 16'h0034);
  endtask : t_reset_latch

  task automatic t_count_rw;
    wr(`TBA_ADDR_COUNT_HI, 8'h01);
    check("count", timerCountValue, 16'h0034);
    wr(`TBA_ADDR_COUNT_LO, 8'hff);
    check("count", timerCountValue, 16'h01ff);
    u_core.read16(`TBA_ADDR_COUNT_LO, v);
    check("count rd", v, 16'h01ff);
  endtask : t_count_rw

  task automatic t_latch_share;
    wr(`TBA_ADDR_CMPA_HI, 8'h12);
    wr(`TBA_ADDR_CMPA_LO, 8'h34);
    wr(`TBA_ADDR_CMPB_LO, 8'h56);
    wr(`TBA_ADDR_COUNT_LO, 8'h78);
    check("cmpA", compareValueA, 16'h1234);
    check("cmpB", compareValueB, 16'h1256);
    check("count", timerCountValue, 16'h1278);
  endtask : t_latch_share

  task automatic t_compare_read;
    u_core.write16(`TBA_ADDR_CMPA_LO, 16'ha55a);
    u_core.byte_op(1'b0, `TBA_ADDR_COUNT_LO, 8'h00, junk);
    u_core.read16(`TBA_ADDR_CMPA_LO, v);
    check("cmpA rd", v, 16'ha55a);
    u_core.read16(`TBA_ADDR_CMPB_LO, v);
    check("cmpB rd", v, 16'h1256);
    u_core.byte_op(1'b0, `TBA_ADDR_COUNT_HI, 8'h00, junk);
    check("latch", {8'h00, junk}, 16'h0012);
  endtask : t_compare_read

  task automatic t_capture_top;
    u_core.write16(`TBA_ADDR_CAP_LO, 16'h0333);
    check("cap", captureValue, 16'h0000);
    waveformModeSelect = TBA_WM_CTC_CAP;
    u_core.write16(`TBA_ADDR_CAP_LO, 16'h0333);
    check("cap", captureValue, 16'h0333);
    for (int m = 0; m < 16; m++) begin
      waveformModeSelect = m[3:0];
      tick(2);
      check("top", topValue, top_for(m[3:0]));
    end
    waveformModeSelect = TBA_WM_NORMAL;
  endtask : t_capture_top

  task automatic t_priority_flags;
    wr(`TBA_ADDR_COUNT_HI, 8'h00);
    countClear = 1'b1;
    countStep = 1'b1;
    wr(`TBA_ADDR_COUNT_LO, 8'h01);
    check("count", timerCountValue, 16'h0001);
    countClear = 1'b0;
    countDown = 1'b1;
    tick(2);
    countStep = 1'b0;
    check("count", timerCountValue, 16'hffff);
    check("floor", {15'h0, countFloorPoint}, 16'h0001);
    tick(1);
    check("max", {15'h0, countMaxPoint}, 16'h0001);
    check("top", {15'h0, countTopPoint}, 16'h0001);
    captureStrobe = 1'b1;
    tick(1);
    captureStrobe = 1'b0;
    u_core.read16(`TBA_ADDR_CAP_LO, v);
    check("cap rd", v, 16'hffff);
  endtask : t_priority_flags

  task automatic t_freeze;
    clkEn = 1'b0;
    countStep = 1'b1;
    wr(`TBA_ADDR_COUNT_HI, 8'h55);
    check("count", timerCountValue, 16'hffff);
    clkEn = 1'b1;
    countStep = 1'b0;
    u_core.byte_op(1'b0, `TBA_ADDR_COUNT_HI, 8'h00, junk);
    check("latch", {8'h00, junk}, 16'h00ff);
  endtask : t_freeze

  task automatic tallyAndFinish;
    if (badCount == 0 && nCompared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tallyAndFinish

  initial begin
    #(3000 * 20);
    badCount++;
    tallyAndFinish();
  end

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset_latch();
    t_count_rw();
    t_latch_share();
    t_compare_read();
    t_capture_top();
    t_priority_flags();
    t_freeze();
    tallyAndFinish();
  end

endmodule : tba_timer16_byte_access_bench
